// *** core/iopr_pkg.sv ***
/*
 the package of the remappable port block: register map, field sizes, reset values and
 routing codes shared by the core and the bench.
 assumes a 16-bit register port clocked by clk_sys.
*/
package iopr_pkg;
   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NUM_PINS = 26;
   localparam int NUM_CN = 31;
   localparam int NUM_IN = 14;
   localparam int SEL_W = 5;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CLK_HZ = 50_000_000;

   // ************************************************************
   // register offsets (word index)
   // ************************************************************
   localparam logic [7:0] A_DIR_LO = 8'h0_0;
   localparam logic [7:0] A_DIR_HI = 8'h0_1;
   localparam logic [7:0] A_LVL_LO = 8'h0_2;
   localparam logic [7:0] A_LVL_HI = 8'h0_3;
   localparam logic [7:0] A_LAT_LO = 8'h0_4;
   localparam logic [7:0] A_LAT_HI = 8'h0_5;
   localparam logic [7:0] A_ODC_LO = 8'h0_6;
   localparam logic [7:0] A_ODC_HI = 8'h0_7;
   localparam logic [7:0] A_ANA_LO = 8'h0_8;
   localparam logic [7:0] A_ANA_HI = 8'h0_9;
   localparam logic [7:0] A_CNEN_LO = 8'h0_A;
   localparam logic [7:0] A_CNEN_HI = 8'h0_B;
   localparam logic [7:0] A_CNPU_LO = 8'h0_C;
   localparam logic [7:0] A_CNPU_HI = 8'h0_D;
   localparam logic [7:0] A_OSC = 8'h0_E;
   localparam logic [7:0] A_STAT = 8'h0_F;
   localparam logic [7:0] A_IN_BASE = 8'h1_0;
   localparam logic [7:0] A_OUT_BASE = 8'h2_0;

   // ************************************************************
   // fields, keys and reset values
   // ************************************************************
   localparam int LOCK_BIT = 6;
   localparam logic [7:0] KEY_ONE = 8'h4_6;
   localparam logic [7:0] KEY_TWO = 8'h5_7;
   localparam logic [4:0] SEL_GND = 5'h1_F;
   localparam logic [4:0] OUT_NULL = 5'h0_0;
   localparam logic [4:0] OUT_TX = 5'h0_3;
   localparam logic [4:0] OUT_RTS = 5'h0_4;
   localparam logic [4:0] OUT_SDO = 5'h0_7;
   localparam logic [4:0] OUT_SCK = 5'h0_8;
   localparam logic [4:0] OUT_SS = 5'h0_9;
   localparam logic [4:0] OUT_OC1 = 5'h1_2;
   localparam logic [4:0] OUT_OC2 = 5'h1_3;
   localparam logic [31:0] DIR_RESET = 32'hFFFF_FFFF;

   // peripheral input order
   typedef enum logic [3:0] {
      IN_INT1 = 4'h0, IN_INT2 = 4'h1, IN_T2CK = 4'h2, IN_T3CK = 4'h3,
      IN_CAP1 = 4'h4, IN_CAP2 = 4'h5, IN_CAP7 = 4'h6, IN_CAP8 = 4'h7,
      IN_FLTA = 4'h8, IN_RX = 4'h9, IN_CTS = 4'hA, IN_SDI = 4'hB,
      IN_SCKI = 4'hC, IN_SSI = 4'hD
   } iopr_in_t;

   typedef enum logic [1:0] {
      LK_IDLE = 2'b00, LK_ONE = 2'b01, LK_OPEN = 2'b10
   } iopr_lock_st_t;

   // peripheral outputs bundled
   typedef struct packed {
      logic tx;
      logic rts;
      logic sdo;
      logic sck;
      logic ss;
      logic oc1;
      logic oc2;
   } iopr_periph_out_t;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } iopr_bus_req_t;
endpackage

// *** core/iopr_core.sv ***
/*
 the remappable port block: port latch, direction, open drain, analog read masking,
 change notification with pull-ups, peripheral input and output routing with a lock.
 assumes pins are synchronous to clk_sys and a single-cycle register port.
*/
`timescale 1ns/100ps
module iopr_core (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire iopr_pkg::iopr_bus_req_t bus_req,
   output logic [iopr_pkg::DATA_W-1:0] rd_data,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic [31:0] pullup_en,
   input wire iopr_pkg::iopr_periph_out_t periph_out,
   output logic [iopr_pkg::NUM_IN-1:0] periph_in,
   output logic change_irq,
   output logic mismatch_reset
);
   import iopr_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic [31:0] dir_ff, nxt_dir;
   logic [31:0] lat_ff, nxt_lat;
   logic [31:0] odc_ff, nxt_odc;
   logic [31:0] ana_ff, nxt_ana;
   logic [31:0] cnen_ff, nxt_cnen;
   logic [31:0] cnpu_ff, nxt_cnpu;
   logic [31:0] last_ff, nxt_last;
   logic [31:0] lvl_ff;
   logic irq_ff, nxt_irq;
   logic lock_ff, nxt_lock;
   iopr_lock_st_t lk_ff, nxt_lk;
   logic [SEL_W-1:0] insel_ff [NUM_IN];
   logic [SEL_W-1:0] nxt_insel [NUM_IN];
   logic [SEL_W-1:0] insh_ff [NUM_IN];
   logic [SEL_W-1:0] outsel_ff [NUM_PINS];
   logic [SEL_W-1:0] nxt_outsel [NUM_PINS];
   logic [SEL_W-1:0] outsh_ff [NUM_PINS];
   logic mis_ff, nxt_mis;
   logic [DATA_W-1:0] rd_ff, nxt_rd;
   logic [31:0] pin_val;
   logic [31:0] drv_val;
   logic [31:0] drv_en;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                            input logic [15:0] d);
      logic [31:0] r;
      r = old;
      if (hi) begin
         r[31:16] = d;
      end else begin
         r[15:0] = d;
      end
      return r;
   endfunction

   function automatic logic [15:0] get_half(input logic [31:0] v, input logic hi);
      return hi ? v[31:16] : v[15:0];
   endfunction

   // peripheral output picked by a pin's output code
   function automatic logic route_val(input logic [SEL_W-1:0] sel,
                                      input iopr_periph_out_t po);
      logic v;
      unique case (sel)
         OUT_TX: v = po.tx;
         OUT_RTS: v = po.rts;
         OUT_SDO: v = po.sdo;
         OUT_SCK: v = po.sck;
         OUT_SS: v = po.ss;
         OUT_OC1: v = po.oc1;
         OUT_OC2: v = po.oc2;
         default: v = 1'b0; // unassigned codes drive low
      endcase
      return v;
   endfunction

   // routing register decode, shared by the write and read paths
   function automatic logic is_in_sel(input logic [ADDR_W-1:0] ad);
      return (ad[7:4] == A_IN_BASE[7:4]) && (ad[3:0] < 4'(NUM_IN));
   endfunction

   function automatic logic is_out_sel(input logic [ADDR_W-1:0] ad);
      return (ad[7:5] == A_OUT_BASE[7:5]) && (ad[4:0] < 5'(NUM_PINS));
   endfunction

   // ************************************************************
   // pin drive
   // ************************************************************
   generate
      for (genvar p = 0; p < 32; p++) begin : g_drv
         if (p < NUM_PINS) begin : g_rp
            // a routed peripheral owns the pin whatever the direction bit says
            assign drv_en[p] = (outsel_ff[p] != OUT_NULL) | ~dir_ff[p];
            assign drv_val[p] = (outsel_ff[p] != OUT_NULL) ?
                                route_val(outsel_ff[p], periph_out) : lat_ff[p];
         end else begin : g_port
            assign drv_en[p] = ~dir_ff[p];
            assign drv_val[p] = lat_ff[p];
         end
         // open drain: never drive high, release instead
         assign pin_oe[p] = drv_en[p] & ~(odc_ff[p] & drv_val[p]);
         assign pin_out[p] = odc_ff[p] ? 1'b0 : drv_val[p];
      end
   endgenerate

   assign pullup_en = cnpu_ff;
   assign pin_val = pin_in;

   // ************************************************************
   // input routing
   // ************************************************************
   generate
      for (genvar i = 0; i < NUM_IN; i++) begin : g_in
         // selects 26 to 30 have no pin behind them and read as ground
         assign periph_in[i] = (insel_ff[i] < SEL_W'(NUM_PINS)) ?
                               pin_val[insel_ff[i]] : 1'b0;
      end
   endgenerate

   // ************************************************************
   // registers, lock and change notification
   // ************************************************************
   always_comb begin
      logic hi;
      logic [31:0] diff;
      logic rt_ok;
      hi = bus_req.addr[0];
      nxt_dir = dir_ff;
      nxt_lat = lat_ff;
      nxt_odc = odc_ff;
      nxt_ana = ana_ff;
      nxt_cnen = cnen_ff;
      nxt_cnpu = cnpu_ff;
      nxt_lock = lock_ff;
      nxt_lk = lk_ff;
      nxt_insel = insel_ff;
      nxt_outsel = outsel_ff;
      nxt_rd = '0;
      rt_ok = ~lock_ff;
      // stored levels follow pins; disabled pins never flag
      diff = (pin_in ^ last_ff) & cnen_ff;
      nxt_last = pin_in;
      nxt_irq = irq_ff | (|diff);
      if (bus_req.wr) begin
         if (bus_req.addr == A_OSC) begin
            unique case (lk_ff)
               LK_IDLE: nxt_lk = (bus_req.wdata[7:0] == KEY_ONE) ? LK_ONE : LK_IDLE;
               LK_ONE: nxt_lk = (bus_req.wdata[7:0] == KEY_TWO) ? LK_OPEN : LK_IDLE;
               LK_OPEN: begin
                  nxt_lock = bus_req.wdata[LOCK_BIT];
                  nxt_lk = LK_IDLE;
               end
               default: nxt_lk = LK_IDLE;
            endcase
         end else begin
            // any write elsewhere breaks the key sequence
            nxt_lk = LK_IDLE;
         end
         unique case (bus_req.addr[7:1])
            A_DIR_LO[7:1]: nxt_dir = put_half(dir_ff, hi, bus_req.wdata);
            A_LVL_LO[7:1], A_LAT_LO[7:1]: nxt_lat = put_half(lat_ff, hi, bus_req.wdata);
            A_ODC_LO[7:1]: nxt_odc = put_half(odc_ff, hi, bus_req.wdata);
            A_ANA_LO[7:1]: nxt_ana = put_half(ana_ff, hi, bus_req.wdata);
            A_CNEN_LO[7:1]: nxt_cnen = put_half(cnen_ff, hi, bus_req.wdata);
            A_CNPU_LO[7:1]: nxt_cnpu = put_half(cnpu_ff, hi, bus_req.wdata);
            default: ;
         endcase
         // a clear meeting a new change in one cycle loses; the change stays
         if (bus_req.addr == A_STAT) begin
            nxt_irq = (irq_ff & ~bus_req.wdata[0]) | (|diff); // set wins
         end
         if (rt_ok && is_in_sel(bus_req.addr)) begin
            nxt_insel[bus_req.addr[3:0]] = bus_req.wdata[SEL_W-1:0];
         end
         if (rt_ok && is_out_sel(bus_req.addr)) begin
            nxt_outsel[bus_req.addr[4:0]] = bus_req.wdata[SEL_W-1:0];
         end
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr[7:1])
            A_DIR_LO[7:1]: nxt_rd = get_half(dir_ff, hi);
            A_LVL_LO[7:1]: nxt_rd = get_half(lvl_ff & ~ana_ff, hi);
            A_LAT_LO[7:1]: nxt_rd = get_half(lat_ff, hi);
            A_ODC_LO[7:1]: nxt_rd = get_half(odc_ff, hi);
            A_ANA_LO[7:1]: nxt_rd = get_half(ana_ff, hi);
            A_CNEN_LO[7:1]: nxt_rd = get_half(cnen_ff, hi);
            A_CNPU_LO[7:1]: nxt_rd = get_half(cnpu_ff, hi);
            default: nxt_rd = '0;
         endcase
         if (bus_req.addr == A_OSC) begin
            nxt_rd = DATA_W'({lock_ff, 6'h0_0});
         end
         if (bus_req.addr == A_STAT) begin
            nxt_rd = {14'h0_000, mis_ff, irq_ff};
         end
         if (is_in_sel(bus_req.addr)) begin
            nxt_rd = DATA_W'(insel_ff[bus_req.addr[3:0]]);
         end
         if (is_out_sel(bus_req.addr)) begin
            nxt_rd = DATA_W'(outsel_ff[bus_req.addr[4:0]]);
         end
      end
   end

   // shadows hold the last legal value; any upset shows as a difference
   always_comb begin
      nxt_mis = mis_ff;
      for (int i = 0; i < NUM_IN; i++) begin
         if (insel_ff[i] != insh_ff[i]) nxt_mis = 1'b1;
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         if (outsel_ff[p] != outsh_ff[p]) nxt_mis = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dir_ff <= DIR_RESET;
         lat_ff <= '0;
         odc_ff <= '0;
         ana_ff <= '0;
         cnen_ff <= '0;
         cnpu_ff <= '0;
         last_ff <= '0;
         lvl_ff <= '0;
         irq_ff <= 1'b0;
         lock_ff <= 1'b0;
         lk_ff <= LK_IDLE;
         mis_ff <= 1'b0;
         rd_ff <= '0;
      end else begin
         dir_ff <= nxt_dir;
         lat_ff <= nxt_lat;
         odc_ff <= nxt_odc;
         ana_ff <= nxt_ana;
         cnen_ff <= nxt_cnen;
         cnpu_ff <= nxt_cnpu;
         last_ff <= nxt_last;
         lvl_ff <= pin_in; // one-cycle pin sample, hence the settle gap
         irq_ff <= nxt_irq;
         lock_ff <= nxt_lock;
         lk_ff <= nxt_lk;
         mis_ff <= nxt_mis;
         rd_ff <= nxt_rd;
      end
   end

   // routing selects and their shadows; the reset value grounds every input
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_IN; i++) begin
            insel_ff[i] <= SEL_GND;
            insh_ff[i] <= SEL_GND;
         end
         for (int p = 0; p < NUM_PINS; p++) begin
            outsel_ff[p] <= OUT_NULL;
            outsh_ff[p] <= OUT_NULL;
         end
      end else begin
         insel_ff <= nxt_insel;
         insh_ff <= nxt_insel;
         outsel_ff <= nxt_outsel;
         outsh_ff <= nxt_outsel;
      end
   end

   assign rd_data = rd_ff;
   assign change_irq = irq_ff;
   assign mismatch_reset = mis_ff;
endmodule

// *** tb/iopr_core_chk.sv ***
/*
 concurrent checks on the pins and register port of the remappable port block.
 assumes it is bound to iopr_core and sees every register write on bus_req.
*/
`timescale 1ns/100ps
module iopr_core_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire iopr_pkg::iopr_bus_req_t bus_req,
   input wire logic [iopr_pkg::DATA_W-1:0] rd_data,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pullup_en,
   input wire iopr_pkg::iopr_periph_out_t periph_out,
   input wire logic [iopr_pkg::NUM_IN-1:0] periph_in,
   input wire logic change_irq,
   input wire logic mismatch_reset
);
   import iopr_pkg::*;
   // ********
   // shadows
   // ********
   logic [15:0] odc_ff, nxt_odc, ana_ff, nxt_ana;
   logic [31:0] cn_ff, nxt_cn, pq_ff;
   logic [1:0] live_ff, nxt_live;
   logic chg;
   // enabled pin differs from its level one cycle back
   assign chg = |((pin_in ^ pq_ff) & cn_ff);
   always_comb begin
      nxt_odc = odc_ff;
      nxt_ana = ana_ff;
      nxt_cn = cn_ff;
      nxt_live = live_ff + {1'b0, ~live_ff[1]};
      if (bus_req.wr) begin
         case (bus_req.addr)
            A_ODC_LO: nxt_odc = bus_req.wdata;
            A_ANA_LO: nxt_ana = bus_req.wdata;
            A_CNEN_LO: nxt_cn[15:0] = bus_req.wdata;
            A_CNEN_HI: nxt_cn[31:16] = bus_req.wdata;
            default: nxt_odc = odc_ff;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      pq_ff <= pin_in;
      if (!resetn) begin
         odc_ff <= 16'h0000;
         ana_ff <= 16'h0000;
         cn_ff <= 32'h0000_0000;
         live_ff <= 2'h0;
      end else begin
         odc_ff <= nxt_odc;
         ana_ff <= nxt_ana;
         cn_ff <= nxt_cn;
         live_ff <= nxt_live;
      end
   end
   // ********
   // checks
   // ********
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   property p_od; (odc_ff & pin_oe[15:0] & pin_out[15:0]) == 16'h0000; endproperty
   a_od: assert property (p_od) else $error("open-drain pin driven high");
   property p_ana; bus_req.rd && bus_req.addr == A_LVL_LO |=> (rd_data & ana_ff) == 16'h0000;
   endproperty
   a_ana: assert property (p_ana) else $error("analog bit read as one");
   property p_cn_set; live_ff[1] && chg |-> ##[1:2] change_irq; endproperty
   a_cn_set: assert property (p_cn_set) else $error("change request missing");
   property p_cn_src; $rose(change_irq) |-> $past(chg) || $past(chg, 2); endproperty
   a_cn_src: assert property (p_cn_src) else $error("change request without cause");
   property p_pu; bus_req.wr && bus_req.addr == A_CNPU_HI |=> pullup_en[31:16] ==
      $past(bus_req.wdata); endproperty
   a_pu: assert property (p_pu) else $error("pull-up enable wrong");
   property p_rd0; !bus_req.rd |=> rd_data == 16'h0000; endproperty
   a_rd0: assert property (p_rd0) else $error("read data outside read slot");
   property p_dir; bus_req.wr && bus_req.addr == A_DIR_HI |=> {pin_oe[31:26], 10'h000} ==
      (~$past(bus_req.wdata) & 16'hFC00); endproperty
   a_dir: assert property (p_dir) else $error("drive enable not from direction");
   property p_mm; !mismatch_reset; endproperty
   a_mm: assert property (p_mm) else $error("spurious mismatch reset");
   c_irq: cover property ($rose(change_irq));
   c_od: cover property (|(odc_ff & pin_oe[15:0]));
   c_lvl: cover property (bus_req.rd && bus_req.addr == A_LVL_LO);
endmodule
bind iopr_core iopr_core_chk u_chk (.clk_sys, .resetn, .bus_req, .rd_data, .pin_in, .pin_out,
   .pin_oe, .pullup_en, .periph_out, .periph_in, .change_irq, .mismatch_reset);

// *** tb/iopr_pins.sv ***
/*
 model of the pads and peripherals around the remappable port block.
 assumes the core's drive wins over the outside driver on a pin.
*/
`timescale 1ns/100ps
module iopr_pins (
   input wire logic clk_sys,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] ext_val,
   output logic [31:0] pin_in,
   output iopr_pkg::iopr_periph_out_t periph_out
);
   import iopr_pkg::*;
   // ********
   // pads and peripherals
   // ********
   logic [6:0] lfsr_ff = 7'h01;
   // outputs move every cycle so a stuck route cannot pass
   assign periph_out = iopr_periph_out_t'(lfsr_ff);
   // a driven pin reads back its own drive, analog ones too
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
   always_ff @(posedge clk_sys) begin
      lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
   end
endmodule

// *** tb/io_port_remap_and_change_notify_test.sv ***
/*
 self-checking bench for the remappable port block.
 assumes iopr_core, its checker and the pad model are compiled first.
*/
`timescale 1ns/100ps
module io_port_remap_and_change_notify_test;
   import iopr_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   iopr_bus_req_t bus_req = '0;
   logic [15:0] rd_data, d, l, o, a, e;
   logic [31:0] pin_in, pin_out, pin_oe, pullup_en;
   logic [31:0] ext_val = 32'h0000_0000;
   iopr_periph_out_t periph_out;
   logic [NUM_IN-1:0] periph_in;
   logic change_irq, mismatch_reset;
   logic [4:0] s;
   logic [4:0] codes [8] = '{OUT_NULL, OUT_TX, OUT_RTS, OUT_SDO, OUT_SCK, OUT_SS,
      OUT_OC1, OUT_OC2};
   int n_fail = 0;
   int n_compared = 0;
   iopr_core dut (.clk_sys, .resetn, .bus_req, .rd_data, .pin_in, .pin_out, .pin_oe,
      .pullup_en, .periph_out, .periph_in, .change_irq, .mismatch_reset);
   iopr_pins u_pins (.clk_sys, .pin_out, .pin_oe, .ext_val, .pin_in, .periph_out);
   // ********
   // helpers
   // ********
   function automatic logic exp_route(input logic [4:0] c, input iopr_periph_out_t p);
      case (c)
         OUT_TX: return p.tx;
         OUT_RTS: return p.rts;
         OUT_SDO: return p.sdo;
         OUT_SCK: return p.sck;
         OUT_SS: return p.ss;
         OUT_OC1: return p.oc1;
         OUT_OC2: return p.oc2;
         default: return 1'b0;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic put(input logic [7:0] ad, input logic [15:0] wd);
      bus_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
   endtask
   task automatic idle();
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic get(input logic [7:0] ad, input logic [15:0] ex);
      bus_req <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      @(posedge clk_sys);
      chk("rd_data", 32'(ex), 32'(rd_data));
   endtask
   task automatic lock_seq(input logic [15:0] mid, input logic [15:0] last);
      put(A_OSC, {8'h00, KEY_ONE});
      put(A_OSC, mid);
      put(A_OSC, last);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ********
   // run
   // ********
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #100_000;
      n_fail++;
      summarize();
   end
   initial begin
      void'($urandom(92756));
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk("pin_oe", 32'h0000_0000, pin_oe);
      chk("periph_in", 32'h0000_0000, 32'(periph_in));
      get(A_DIR_LO, DIR_RESET[15:0]);
      get(A_IN_BASE + 8'h05, {11'h000, SEL_GND});
      for (int i = 0; i < 8; i++) begin
         a = 16'($urandom());
         d = 16'($urandom()) | a;
         l = 16'($urandom());
         o = (i == 0) ? 16'hFFFF : 16'($urandom());
         e = ~d & ~(o & l);
         ext_val <= $urandom();
         put(A_DIR_LO, d);
         put(A_LAT_LO, l);
         put(A_ODC_LO, o);
         put(A_ANA_LO, a);
         idle();
         chk("pin_oe", 32'(e), 32'(pin_oe[15:0]));
         chk("pin_out", 32'(e & l), 32'(pin_out[15:0] & e));
         get(A_LVL_LO, ((e & l) | (~e & ext_val[15:0])) & ~a);
      end
      put(A_DIR_LO, 16'hFFFF);
      for (int n = 0; n < NUM_IN; n++) begin
         s = (n == 3) ? SEL_GND : 5'($urandom_range(25, 0));
         s = (n == 0) ? 5'h19 : s;
         ext_val <= $urandom();
         put(A_IN_BASE + 8'(n), {11'h000, s});
         idle();
         chk("periph_in", 32'((s == SEL_GND) ? 1'b0 : ext_val[s]), 32'(periph_in[n]));
      end
      for (int k = 0; k < 8; k++) begin
         put(A_OUT_BASE + 8'h14, {11'h000, codes[k]});
         idle();
         repeat (2) begin
            chk("route_oe", 32'(codes[k] != OUT_NULL), 32'(pin_oe[20]));
            chk("route_out", 32'(exp_route(codes[k], periph_out)), 32'(pin_out[20]));
            @(posedge clk_sys);
         end
      end
      for (int j = 0; j < 3; j++) begin
         lock_seq((j == 1) ? 16'h0000 : {8'h00, KEY_TWO}, (j == 0) ? 16'h0040 : 16'h0000);
         put(A_OUT_BASE + 8'h14, {11'h000, OUT_TX});
         idle();
         get(A_OUT_BASE + 8'h14, {11'h000, (j == 2) ? OUT_TX : OUT_OC2});
      end
      put(A_CNEN_HI, 16'h4000);
      idle();
      for (int j = 0; j < 2; j++) begin
         ext_val <= ext_val ^ ((j == 0) ? 32'h2000_0000 : 32'h4000_0000);
         repeat (2) @(posedge clk_sys);
         chk("change_irq", 32'(j), 32'(change_irq));
      end
      put(A_STAT, 16'h0001);
      idle();
      get(A_STAT, 16'h0000);
      d = 16'($urandom());
      put(A_CNPU_HI, d);
      idle();
      chk("pullup_en", 32'(d), 32'(pullup_en[31:16]));
      put(A_CNPU_HI, 16'h0000);
      put(A_DIR_HI, 16'h03FF);
      idle();
      chk("pin_oe", 32'h0000_003F, 32'(pin_oe[31:26]));
      chk("mismatch_reset", 32'h0000_0000, 32'(mismatch_reset));
      summarize();
   end
endmodule
